/* File: tb/mphp_host_model.sv */
// Behavioural host processor that drives the parallel port pins.
`timescale 1ns/10ps
`default_nettype none
module mphp_host_model (
	input  wire logic       mclk_i,
	input  wire logic [7:0] dev_data_i,
	input  wire logic       dev_oe_i,
	output logic            reset_n_o,
	output logic            cs_n_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic [2:0]      addr_o,
	output logic [7:0]      bus_o
);
	logic       drv_r;
	logic [7:0] hd_r, last_r;
	initial begin
		reset_n_o = 1'b1; cs_n_o = 1'b1; rd_n_o = 1'b1; wr_n_o = 1'b1;
		addr_o = 3'h0; drv_r = 1'b0; hd_r = 8'h00; last_r = 8'h00;
	end
	// A released bus shows the inverse of its last driven value.
	always_comb bus_o = dev_oe_i ? dev_data_i : drv_r ? hd_r : ~last_r;
	// Remember the last value that a party drove.
	always @(posedge mclk_i) if (dev_oe_i || drv_r) last_r <= bus_o;
	// One byte access; strobes held well past the synchroniser delay.
	task access(input logic w, input logic sel, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk_i);
		cs_n_o <= !sel; addr_o <= a; hd_r <= d; drv_r <= w;
		rd_n_o <= w; wr_n_o <= !w;
		repeat (8) @(posedge mclk_i);
		q = bus_o;
		cs_n_o <= 1'b1; rd_n_o <= 1'b1; wr_n_o <= 1'b1;
		repeat (6) @(posedge mclk_i);
		drv_r <= 1'b0;
	endtask : access
	// Pulse the reset pin low for six cycles.
	task pulse_reset;
		@(posedge mclk_i);
		reset_n_o <= 1'b0;
		repeat (6) @(posedge mclk_i);
		reset_n_o <= 1'b1;
	endtask : pulse_reset
endmodule : mphp_host_model
`default_nettype wire

/* File: tb/mphp_host_port_asserts.sv */
// Concurrent checks on the pins and service bus of the host port.
`timescale 1ns/10ps
`default_nettype none
module mphp_port_asserts #(
	parameter int unsigned CYC = 20
) (
	input wire logic       mclk_i,
	input wire logic       rst_i,
	input wire logic       host_reset_n_i,
	input wire logic       device_select_n_i,
	input wire logic       host_rd_n_i,
	input wire logic [7:0] host_data_o,
	input wire logic       host_data_oe_o,
	input wire logic       host_int_o,
	input wire logic       ready_o,
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	input wire logic       irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic [31:0] sel_r, sel_nxt, rdh_r, rdh_nxt, rdl_r, rdl_nxt, wt_r, wt_nxt;
	// ------------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------------
	// Count idle select, idle strobe, held read and time spent not ready.
	always_comb begin
		sel_nxt = device_select_n_i ? sel_r + 32'h1 : 32'h0;
		rdh_nxt = host_rd_n_i ? rdh_r + 32'h1 : 32'h0;
		rdl_nxt = 32'h0;
		if (!device_select_n_i && !host_rd_n_i && ready_o) begin
			rdl_nxt = rdl_r + 32'h1;
		end
		wt_nxt = ready_o ? 32'h0 : wt_r + 32'h1;
	end
	// Register the counters; reset clears them.
	always_ff @(posedge mclk_i) begin
		sel_r <= rst_i ? 32'h0 : sel_nxt;
		rdh_r <= rst_i ? 32'h0 : rdh_nxt;
		rdl_r <= rst_i ? 32'h0 : rdl_nxt;
		wt_r  <= rst_i ? 32'h0 : wt_nxt;
	end
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	a_unsel_quiet: assert property (sel_r >= 6 |-> !host_data_oe_o)
		else $error("bus driven while not selected");
	a_bus_release: assert property (rdh_r >= 6 |-> !host_data_oe_o)
		else $error("bus driven without a read");
	a_read_drive: assert property (rdl_r == 7 |-> host_data_oe_o)
		else $error("read not answered");
	a_data_steady: assert property (host_data_oe_o && $past(host_data_oe_o)
		|-> $stable(host_data_o)) else $error("read data moved");
	a_ready_bound: assert property (!ready_o |-> wt_r <= CYC + 24)
		else $error("ready too late");
	a_ready_early: assert property ($rose(ready_o) |-> wt_r >= CYC - 1)
		else $error("ready too early");
	a_reset_quiet: assert property ($fell(rst_i) |-> !host_int_o
		&& !host_data_oe_o && !ready_o && !irq_o) else $error("reset values");
	a_int_reset: assert property ($fell(host_reset_n_i) |-> ##[1:8]
		!host_int_o) else $error("interrupt kept over reset");
	a_wait_once: assert property ($rose(avs_read_i || avs_write_i)
		|-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait");
	a_idle_nowait: assert property (!(avs_read_i || avs_write_i)
		|-> !avs_waitrequest_o) else $error("wait without request");
	c_read: cover property ($rose(host_data_oe_o));
	c_int: cover property ($rose(host_int_o));
	c_irq: cover property ($rose(irq_o));
endmodule : mphp_port_asserts
`default_nettype wire

/* File: tb/mphp_host_port_bench.sv */
// Self-checking bench for the modem parallel host port.
`timescale 1ns/10ps
`default_nettype none
module mphp_host_port_bench;
	localparam int unsigned RDY = 20;
	logic        mclk_i, rst_i, rst_n, cs_n, rd_n, wr_n, oe, hint, rdy;
	logic        wreq, irq, avs_rd, avs_wr;
	logic [2:0]  addr;
	logic [7:0]  bus, dout, avs_a, b, s, rb, lcr, mcr;
	logic [31:0] avs_wd, avs_q, q, n;
	int          miscompares, n_compared;
	mphp_host_port #(.READY_CYCLES_P(RDY)) mphp_host_port_inst (
		.mclk_i(mclk_i), .rst_i(rst_i), .host_reset_n_i(rst_n),
		.device_select_n_i(cs_n), .host_rd_n_i(rd_n), .host_wr_n_i(wr_n),
		.host_addr_i(addr), .host_data_i(bus), .host_data_o(dout),
		.host_data_oe_o(oe), .host_int_o(hint), .ready_o(rdy),
		.avs_address_i(avs_a), .avs_read_i(avs_rd), .avs_write_i(avs_wr),
		.avs_writedata_i(avs_wd), .avs_readdata_o(avs_q),
		.avs_waitrequest_o(wreq), .irq_o(irq));
	mphp_host_model mphp_host_model_inst (.mclk_i(mclk_i),
		.dev_data_i(dout), .dev_oe_i(oe), .reset_n_o(rst_n), .cs_n_o(cs_n),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .bus_o(bus));
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task print_verdict;
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Wait boundedly for host_int (0), irq (1) or ready (2) to reach e.
	task wait_flag(input int w, input logic e);
		logic f;
		for (int i = 0; i < 200; i++) begin
			@(negedge mclk_i);
			f = (w == 0) ? hint : (w == 1) ? irq : rdy;
			if (f === e) break;
		end
		chk({31'h0, f}, {31'h0, e});
		if (f !== e) print_verdict();
	endtask : wait_flag
	// Avalon access; the request holds until waitrequest is seen low.
	task av(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk_i);
		avs_a <= a; avs_wd <= d; avs_wr <= w; avs_rd <= !w;
		for (i = 0; i < 64; i++) begin
			@(posedge mclk_i);
			if (wreq === 1'b0) break;
		end
		q = avs_q;
		avs_wr <= 1'b0; avs_rd <= 1'b0;
		if (i == 64) begin miscompares++; print_verdict(); end
	endtask : av
	task hw(input logic [2:0] a, input logic [7:0] d);
		mphp_host_model_inst.access(1'b1, 1'b1, a, d, rb);
	endtask : hw
	task hr(input logic [2:0] a);
		mphp_host_model_inst.access(1'b0, 1'b1, a, 8'h00, rb);
	endtask : hr
	task tdone(input string t);
		$display("test %s finished", t);
	endtask : tdone
	function automatic logic [31:0] cfg_word(input logic [7:0] dm, dl, mc,
		lc);
		return {dm, dl, mc, lc};
	endfunction : cfg_word
	// ------------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------------
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	initial begin
		rst_i = 1'b1; avs_rd = 1'b0; avs_wr = 1'b0; avs_a = 8'h00;
		avs_wd = 32'h0; miscompares = 0; n_compared = 0;
		void'($urandom(32'hACC6DE8B));
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		av(1'b0, mphp_pkg::OFS_CFG, 32'h0);
		chk(q, mphp_pkg::DEF_CFG);
		chk({31'h0, rdy}, 32'h0);
		av(1'b0, 8'h3C, 32'h0);
		chk(q, 32'h0);
		wait_flag(2, 1'b1);
		tdone("reset");
		b = $urandom; s = $urandom; lcr = 8'h80 | $urandom;
		mcr = $urandom & 8'h1F;
		hw(mphp_pkg::HA_LCR, lcr);
		hw(mphp_pkg::HA_DATA, b);
		hw(mphp_pkg::HA_IER, s);
		lcr[7] = 1'b0;
		hw(mphp_pkg::HA_LCR, lcr);
		hw(mphp_pkg::HA_MCR, mcr);
		av(1'b0, mphp_pkg::OFS_CFG, 32'h0);
		chk(q, cfg_word(s, b, mcr, lcr));
		hr(mphp_pkg::HA_LCR);
		chk({24'h0, rb}, {24'h0, lcr});
		repeat (3) begin
			s = $urandom;
			hw(mphp_pkg::HA_SCR, s);
			mphp_host_model_inst.access(1'b1, 1'b0, mphp_pkg::HA_SCR, ~s, rb);
			hr(mphp_pkg::HA_SCR);
			chk({24'h0, rb}, {24'h0, s});
		end
		tdone("registers");
		b = $urandom;
		hw(mphp_pkg::HA_DATA, b);
		av(1'b0, mphp_pkg::OFS_TXDATA, 32'h0);
		chk(q & 32'h1FF, {23'h0, 1'b1, b});
		hw(mphp_pkg::HA_IER, 8'h02);
		wait_flag(0, 1'b1);
		hr(mphp_pkg::HA_IIR);
		chk({24'h0, rb}, {24'h0, mphp_pkg::IIR_THRE});
		wait_flag(0, 1'b0);
		b = $urandom;
		av(1'b1, mphp_pkg::OFS_RXDATA, {24'h0, b});
		hw(mphp_pkg::HA_IER, 8'h01);
		wait_flag(0, 1'b1);
		hr(mphp_pkg::HA_IIR);
		chk({24'h0, rb}, {24'h0, mphp_pkg::IIR_RDA});
		hr(mphp_pkg::HA_DATA);
		chk({24'h0, rb}, {24'h0, b});
		wait_flag(0, 1'b0);
		av(1'b1, mphp_pkg::OFS_LINEERR, 32'h2);
		hw(mphp_pkg::HA_IER, 8'h04);
		wait_flag(0, 1'b1);
		hr(mphp_pkg::HA_IIR);
		chk({24'h0, rb}, {24'h0, mphp_pkg::IIR_RLS});
		hr(mphp_pkg::HA_LSR);
		chk({24'h0, rb}, 32'h64);
		wait_flag(0, 1'b0);
		tdone("host interrupt");
		n = 32'h1 << mphp_pkg::EV_RBR_RD;
		av(1'b1, mphp_pkg::OFS_IRQEN, n);
		wait_flag(1, 1'b1);
		av(1'b1, mphp_pkg::OFS_IRQEN, 32'h0);
		wait_flag(1, 1'b0);
		av(1'b1, mphp_pkg::OFS_IRQEN, n);
		wait_flag(1, 1'b1);
		av(1'b1, mphp_pkg::OFS_IRQCLR, n);
		wait_flag(1, 1'b0);
		av(1'b0, mphp_pkg::OFS_STATUS, 32'h0);
		chk(q & n, 32'h0);
		tdone("service interrupt");
		for (int k = 0; k < 2; k++) begin
			av(1'b1, mphp_pkg::OFS_IRQCLR, 32'h8);
			n = $urandom & 32'hFFFF1F7F;
			av(1'b1, mphp_pkg::OFS_NVCFG, n);
			av(1'b1, mphp_pkg::OFS_NVCTRL, 32'(k));
			av(1'b1, mphp_pkg::OFS_RXDATA, 32'h5A);
			hw(mphp_pkg::HA_IER, 8'h01);
			wait_flag(0, 1'b1);
			mphp_host_model_inst.pulse_reset();
			wait_flag(0, 1'b0);
			hw(mphp_pkg::HA_SCR, 8'hA5);
			wait_flag(2, 1'b1);
			hr(mphp_pkg::HA_SCR);
			chk({24'h0, rb}, {24'h0, mphp_pkg::DEF_SCR});
			av(1'b0, mphp_pkg::OFS_CFG, 32'h0);
			chk(q, k ? n : 32'(mphp_pkg::DEF_CFG));
			av(1'b0, mphp_pkg::OFS_STATUS, 32'h0);
			chk(q & 32'h8, 32'h8);
		end
		tdone("pin reset");
		print_verdict();
	end
endmodule : mphp_host_port_bench
bind mphp_host_port mphp_port_asserts #(.CYC(READY_CYCLES_P)) chk_inst (
	.mclk_i(mclk_i), .rst_i(rst_i), .host_reset_n_i(host_reset_n_i),
	.device_select_n_i(device_select_n_i), .host_rd_n_i(host_rd_n_i),
	.host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
	.host_int_o(host_int_o), .ready_o(ready_o), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.irq_o(irq_o));
`default_nettype wire

/* File: verilog/mphp_host_port.sv */
// Parallel host port with UART-style registers and an Avalon service side.
`timescale 1ns/10ps
`default_nettype none
module mphp_host_port #(
	parameter int unsigned READY_CYCLES_P = mphp_pkg::READY_CYCLES
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        host_reset_n_i,
	input  wire logic        device_select_n_i,
	input  wire logic        host_rd_n_i,
	input  wire logic        host_wr_n_i,
	input  wire logic [2:0]  host_addr_i,
	input  wire logic [7:0]  host_data_i,
	output logic      [7:0]  host_data_o,
	output logic             host_data_oe_o,
	output logic             host_int_o,
	output logic             ready_o,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             irq_o
);

	// ------------------------------------------------------------------
	// Pin synchronisation and port reset
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MPHP_IDLE  = 3'b001,
		MPHP_READ  = 3'b010,
		MPHP_WRITE = 3'b100
	} mphp_state_t;

	mphp_pkg::mphp_pins_t pins_raw;
	mphp_pkg::mphp_pins_t pins;
	logic                 prst;
	logic                 ready;

	assign pins_raw = '{rst_n: host_reset_n_i, cs_n: device_select_n_i,
		rd_n: host_rd_n_i, wr_n: host_wr_n_i, addr: host_addr_i,
		data: host_data_i};

	mphp_pin_sync #(
		.W    (15),
		.IDLE (mphp_pkg::PINS_IDLE)
	) u_sync (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.pin_i  (pins_raw),
		.val_o  (pins)
	);

	// A low reset pin acts like a full port reset.
	assign prst = rst_i | ~pins.rst_n;

	mphp_ready_timer #(
		.CYCLES (READY_CYCLES_P)
	) u_ready (
		.mclk_i  (mclk_i),
		.rst_i   (prst),
		.ready_o (ready)
	);

	// ------------------------------------------------------------------
	// Avalon decode
	// ------------------------------------------------------------------
	logic                 done_r;
	logic                 acc;
	logic                 rd_acc;
	logic                 wr_acc;
	logic [7:0]           ofs;
	logic                 fw_pop;
	logic                 fw_push;
	logic                 fw_err;
	logic                 fw_msr;
	mphp_pkg::mphp_cfg_t  nv_cfg_r;
	logic                 nv_use_r;

	// Requests are answered on the second edge after they appear.
	assign acc     = (avs_read_i | avs_write_i) & done_r;
	assign rd_acc  = avs_read_i & done_r;
	assign wr_acc  = avs_write_i & done_r;
	assign ofs     = {avs_address_i[7:2], 2'b00};
	assign fw_pop  = rd_acc & (ofs == mphp_pkg::OFS_TXDATA);
	assign fw_push = wr_acc & (ofs == mphp_pkg::OFS_RXDATA);
	assign fw_err  = wr_acc & (ofs == mphp_pkg::OFS_LINEERR);
	assign fw_msr  = wr_acc & (ofs == mphp_pkg::OFS_MODEM);

	// ------------------------------------------------------------------
	// Host-facing register set
	// ------------------------------------------------------------------
	mphp_state_t          st_r, st_nxt;
	logic [2:0]           addr_r, addr_nxt;
	logic [7:0]           hold_r, hold_nxt;
	logic [7:0]           rdo_r, rdo_nxt;
	mphp_pkg::mphp_cfg_t  cfg_r, cfg_nxt;
	logic [3:0]           ier_r, ier_nxt;
	logic [7:0]           fcr_r, fcr_nxt;
	logic [7:0]           scr_r, scr_nxt;
	logic [7:0]           rbr_r, rbr_nxt;
	logic                 rxf_r, rxf_nxt;
	logic [7:0]           thr_r, thr_nxt;
	logic                 txf_r, txf_nxt;
	logic                 thri_r, thri_nxt;
	logic [3:0]           lerr_r, lerr_nxt;
	logic [3:0]           mst_r, mst_nxt;
	logic [3:0]           mdl_r, mdl_nxt;
	logic                 int_r, int_nxt;
	logic [mphp_pkg::EV_W-1:0] ev;
	logic                 divisor_latch_select_bit;
	logic                 sel;
	logic                 p_rls;
	logic                 p_rda;
	logic                 p_thre;
	logic                 p_ms;
	logic [7:0]           iir;
	logic [7:0]           lsr;
	logic [7:0]           rd_mux;

	assign divisor_latch_select_bit = cfg_r.lcr[mphp_pkg::LCR_DIVISOR_LATCH_SELECT_BIT];
	assign sel  = ~pins.cs_n & ready;

	// Pending conditions, each gated by its enable.
	assign p_rls  = ier_r[mphp_pkg::IER_RLS] & (|lerr_r);
	assign p_rda  = ier_r[mphp_pkg::IER_RDA] & rxf_r;
	assign p_thre = ier_r[mphp_pkg::IER_THRE] & thri_r;
	assign p_ms   = ier_r[mphp_pkg::IER_MS] & (|mdl_r);

	// Identification code by priority, and line status layout.
	always_comb begin
		iir = mphp_pkg::IIR_NONE;
		if (p_rls) begin
			iir = mphp_pkg::IIR_RLS;
		end else if (p_rda) begin
			iir = mphp_pkg::IIR_RDA;
		end else if (p_thre) begin
			iir = mphp_pkg::IIR_THRE;
		end else if (p_ms) begin
			iir = mphp_pkg::IIR_MS;
		end
		lsr = 8'h00;
		lsr[mphp_pkg::LSR_DR] = rxf_r;
		lsr[mphp_pkg::LSR_ERR_LSB +: 4] = lerr_r;
		lsr[mphp_pkg::LSR_THRE] = ~txf_r;
		lsr[mphp_pkg::LSR_TEMT] = ~txf_r;
	end

	// Read selection by address and the divisor latch bit.
	always_comb begin
		unique case (pins.addr)
			mphp_pkg::HA_DATA: rd_mux = divisor_latch_select_bit ? cfg_r.dll : rbr_r;
			mphp_pkg::HA_IER:  rd_mux = divisor_latch_select_bit ? cfg_r.dlm : {4'h0, ier_r};
			mphp_pkg::HA_IIR:  rd_mux = iir;
			mphp_pkg::HA_LCR:  rd_mux = cfg_r.lcr;
			mphp_pkg::HA_MCR:  rd_mux = cfg_r.mcr;
			mphp_pkg::HA_LSR:  rd_mux = lsr;
			mphp_pkg::HA_MSR:  rd_mux = {mst_r, mdl_r};
			mphp_pkg::HA_SCR:  rd_mux = scr_r;
		endcase
	end

	// Host access sequencing, register updates and service side effects.
	always_comb begin
		st_nxt = st_r;   addr_nxt = addr_r; hold_nxt = hold_r;
		rdo_nxt = rdo_r; cfg_nxt = cfg_r;   ier_nxt = ier_r;
		fcr_nxt = fcr_r; scr_nxt = scr_r;   rbr_nxt = rbr_r;
		rxf_nxt = rxf_r; thr_nxt = thr_r;   txf_nxt = txf_r;
		thri_nxt = thri_r; lerr_nxt = lerr_r; mst_nxt = mst_r;
		mdl_nxt = mdl_r;
		ev = '0;
		unique case (st_r)
			MPHP_IDLE: begin
				addr_nxt = pins.addr;
				if (sel && !pins.rd_n) begin
					st_nxt  = MPHP_READ;
					rdo_nxt = rd_mux;
					if (pins.addr == mphp_pkg::HA_DATA && !divisor_latch_select_bit) begin
						rxf_nxt = 1'b0;
						ev[mphp_pkg::EV_RBR_RD] = 1'b1;
					end
					if (pins.addr == mphp_pkg::HA_IIR &&
						iir == mphp_pkg::IIR_THRE) begin
						thri_nxt = 1'b0;
					end
					if (pins.addr == mphp_pkg::HA_LSR) begin
						lerr_nxt = 4'h0;
					end
					if (pins.addr == mphp_pkg::HA_MSR) begin
						mdl_nxt = 4'h0;
					end
				end else if (sel && !pins.wr_n) begin
					st_nxt   = MPHP_WRITE;
					hold_nxt = pins.data;
				end
			end
			MPHP_READ: begin
				if (pins.cs_n || pins.rd_n) begin
					st_nxt = MPHP_IDLE;
				end
			end
			MPHP_WRITE: begin
				if (pins.cs_n || pins.wr_n) begin
					st_nxt = MPHP_IDLE;
					ev[mphp_pkg::EV_CFG_WR] = 1'b1;
					unique case (addr_r)
						mphp_pkg::HA_DATA: begin
							if (divisor_latch_select_bit) begin
								cfg_nxt.dll = hold_r;
							end else begin
								thr_nxt  = hold_r;
								txf_nxt  = 1'b1;
								thri_nxt = 1'b0;
								ev[mphp_pkg::EV_THR_WR] = 1'b1;
								ev[mphp_pkg::EV_CFG_WR] = 1'b0;
							end
						end
						mphp_pkg::HA_IER: begin
							if (divisor_latch_select_bit) begin
								cfg_nxt.dlm = hold_r;
							end else begin
								ier_nxt = hold_r[3:0];
							end
						end
						mphp_pkg::HA_IIR: fcr_nxt = hold_r;
						mphp_pkg::HA_LCR: cfg_nxt.lcr = hold_r;
						mphp_pkg::HA_MCR: cfg_nxt.mcr = hold_r;
						mphp_pkg::HA_SCR: scr_nxt = hold_r;
						default: ev[mphp_pkg::EV_CFG_WR] = 1'b0;
					endcase
				end else begin
					hold_nxt = pins.data;
				end
			end
		endcase
		// Firmware events come last so that a set wins over a clear, except that a host THR write keeps thri_r clear.
		if (fw_pop) begin
			txf_nxt  = ev[mphp_pkg::EV_THR_WR];
			thri_nxt = ~ev[mphp_pkg::EV_THR_WR];
		end
		if (fw_push) begin
			rbr_nxt = avs_writedata_i[7:0];
			rxf_nxt = 1'b1;
		end
		if (fw_err) begin
			lerr_nxt = lerr_nxt | avs_writedata_i[3:0];
		end
		if (fw_msr) begin
			mst_nxt = avs_writedata_i[3:0];
			mdl_nxt = mdl_nxt | (avs_writedata_i[3:0] ^ mst_r);
		end
		int_nxt = p_rls | p_rda | p_thre | p_ms;
	end

	// Registers; a port reset reloads stored or factory configuration.
	always_ff @(posedge mclk_i) begin
		if (prst) begin
			st_r   <= MPHP_IDLE;
			addr_r <= 3'h0;
			hold_r <= 8'h00;
			rdo_r  <= 8'h00;
			cfg_r  <= nv_use_r ? nv_cfg_r : mphp_pkg::DEF_CFG;
			ier_r  <= mphp_pkg::DEF_IER;
			fcr_r  <= mphp_pkg::DEF_FCR;
			scr_r  <= mphp_pkg::DEF_SCR;
			rbr_r  <= 8'h00;
			rxf_r  <= 1'b0;
			thr_r  <= 8'h00;
			txf_r  <= 1'b0;
			thri_r <= 1'b0;
			lerr_r <= 4'h0;
			mst_r  <= 4'h0;
			mdl_r  <= 4'h0;
			int_r  <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			addr_r <= addr_nxt;
			hold_r <= hold_nxt;
			rdo_r  <= rdo_nxt;
			cfg_r  <= cfg_nxt;
			ier_r  <= ier_nxt;
			fcr_r  <= fcr_nxt;
			scr_r  <= scr_nxt;
			rbr_r  <= rbr_nxt;
			rxf_r  <= rxf_nxt;
			thr_r  <= thr_nxt;
			txf_r  <= txf_nxt;
			thri_r <= thri_nxt;
			lerr_r <= lerr_nxt;
			mst_r  <= mst_nxt;
			mdl_r  <= mdl_nxt;
			int_r  <= int_nxt;
		end
	end

	// Bit zero of the register maps to bit zero of the bus.
	assign host_data_o    = rdo_r;
	assign host_data_oe_o = (st_r == MPHP_READ);
	assign host_int_o     = int_r;
	assign ready_o        = ready;

	// ------------------------------------------------------------------
	// Avalon slave, stored configuration and event interrupts
	// ------------------------------------------------------------------
	logic [31:0]               rdata_r, rdata_nxt;
	logic                      done_nxt;
	mphp_pkg::mphp_cfg_t       nv_cfg_nxt;
	logic                      nv_use_nxt;
	logic [mphp_pkg::EV_W-1:0] stat_r, stat_nxt;
	logic [mphp_pkg::EV_W-1:0] en_r, en_nxt;
	logic [mphp_pkg::EV_W-1:0] clr;
	logic                      pin_rst_q_r;
	logic                      irq_r, irq_nxt;

	// Read data follows the register state; writes act at acceptance.
	always_comb begin
		done_nxt   = (avs_read_i | avs_write_i) & ~done_r;
		nv_cfg_nxt = nv_cfg_r;
		nv_use_nxt = nv_use_r;
		en_nxt     = en_r;
		clr        = '0;
		unique case (ofs)
			mphp_pkg::OFS_TXDATA: rdata_nxt = {23'h0, txf_r, thr_r};
			mphp_pkg::OFS_CFG:    rdata_nxt = cfg_r;
			mphp_pkg::OFS_NVCFG:  rdata_nxt = nv_cfg_r;
			mphp_pkg::OFS_NVCTRL: rdata_nxt = {31'h0, nv_use_r};
			mphp_pkg::OFS_STATUS: rdata_nxt = {28'h0, stat_r};
			mphp_pkg::OFS_IRQEN:  rdata_nxt = {28'h0, en_r};
			mphp_pkg::OFS_PORT:   rdata_nxt = {12'h0, fcr_r, ier_r, 4'h0,
				host_int_o, rxf_r, txf_r, ready};
			default:              rdata_nxt = 32'h0000_0000;
		endcase
		if (!avs_read_i) begin
			rdata_nxt = 32'h0000_0000;
		end
		if (wr_acc) begin
			unique case (ofs)
				mphp_pkg::OFS_NVCFG:  nv_cfg_nxt = avs_writedata_i;
				mphp_pkg::OFS_NVCTRL: nv_use_nxt = avs_writedata_i[0];
				mphp_pkg::OFS_IRQEN:  en_nxt = avs_writedata_i[3:0];
				mphp_pkg::OFS_IRQCLR: clr = avs_writedata_i[3:0];
				default: ;
			endcase
		end
		stat_nxt = (stat_r & ~clr) | ev;
		stat_nxt[mphp_pkg::EV_PIN_RST] = stat_nxt[mphp_pkg::EV_PIN_RST] |
			(pin_rst_q_r & ~pins.rst_n);
		irq_nxt = |(stat_nxt & en_nxt);
	end

	// Service-side registers are reset only by the system reset.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			done_r      <= 1'b0;
			rdata_r     <= 32'h0000_0000;
			nv_cfg_r    <= mphp_pkg::DEF_CFG;
			nv_use_r    <= 1'b0;
			stat_r      <= '0;
			en_r        <= '0;
			pin_rst_q_r <= 1'b1;
			irq_r       <= 1'b0;
		end else begin
			done_r      <= done_nxt;
			rdata_r     <= rdata_nxt;
			nv_cfg_r    <= nv_cfg_nxt;
			nv_use_r    <= nv_use_nxt;
			stat_r      <= stat_nxt;
			en_r        <= en_nxt;
			pin_rst_q_r <= pins.rst_n;
			irq_r       <= irq_nxt;
		end
	end

	assign avs_readdata_o    = rdata_r;
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~acc;
	assign irq_o             = irq_r;

endmodule : mphp_host_port
`default_nettype wire

/* File: verilog/mphp_pin_sync.sv */
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/10ps
`default_nettype none
module mphp_pin_sync #(
	parameter int unsigned W    = 15,
	parameter logic [W-1:0] IDLE = '0
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] val_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// Each bit takes the new level only when the second and third agree.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
		end
	end

	// The first stage feeds only the second stage.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s1_r <= IDLE;
			s2_r <= IDLE;
			s3_r <= IDLE;
			q_r  <= IDLE;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r  <= q_nxt;
		end
	end

	assign val_o = q_r;

endmodule : mphp_pin_sync
`default_nettype wire

/* File: verilog/mphp_pkg.sv */
// Constants and carrier types shared by the modem parallel host port files.
package mphp_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned READY_TIME_S = 6;
	localparam int unsigned READY_CYCLES = CLK_HZ * READY_TIME_S;
	localparam int unsigned READY_CNT_W  = 29;

	// ------------------------------------------------------------------
	// Host register addresses and fields
	// ------------------------------------------------------------------
	localparam logic [2:0] HA_DATA = 3'h0;
	localparam logic [2:0] HA_IER  = 3'h1;
	localparam logic [2:0] HA_IIR  = 3'h2;
	localparam logic [2:0] HA_LCR  = 3'h3;
	localparam logic [2:0] HA_MCR  = 3'h4;
	localparam logic [2:0] HA_LSR  = 3'h5;
	localparam logic [2:0] HA_MSR  = 3'h6;
	localparam logic [2:0] HA_SCR  = 3'h7;

	localparam int unsigned LCR_DIVISOR_LATCH_SELECT_BIT    = 7;
	localparam int unsigned IER_RDA     = 0;
	localparam int unsigned IER_THRE    = 1;
	localparam int unsigned IER_RLS     = 2;
	localparam int unsigned IER_MS      = 3;
	localparam int unsigned LSR_DR      = 0;
	localparam int unsigned LSR_ERR_LSB = 1;
	localparam int unsigned LSR_THRE    = 5;
	localparam int unsigned LSR_TEMT    = 6;

	localparam logic [7:0] IIR_NONE = 8'h01;
	localparam logic [7:0] IIR_RLS  = 8'h06;
	localparam logic [7:0] IIR_RDA  = 8'h04;
	localparam logic [7:0] IIR_THRE = 8'h02;
	localparam logic [7:0] IIR_MS   = 8'h00;

	// ------------------------------------------------------------------
	// Factory defaults
	// ------------------------------------------------------------------
	localparam logic [7:0] DEF_LCR = 8'h03;
	localparam logic [7:0] DEF_MCR = 8'h00;
	localparam logic [7:0] DEF_DLL = 8'h0C;
	localparam logic [7:0] DEF_DLM = 8'h00;
	localparam logic [3:0] DEF_IER = 4'h0;
	localparam logic [7:0] DEF_FCR = 8'h00;
	localparam logic [7:0] DEF_SCR = 8'h00;

	// ------------------------------------------------------------------
	// Avalon register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_TXDATA  = 8'h00;
	localparam logic [7:0] OFS_RXDATA  = 8'h04;
	localparam logic [7:0] OFS_LINEERR = 8'h08;
	localparam logic [7:0] OFS_MODEM   = 8'h0C;
	localparam logic [7:0] OFS_CFG     = 8'h10;
	localparam logic [7:0] OFS_NVCFG   = 8'h14;
	localparam logic [7:0] OFS_NVCTRL  = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_IRQEN   = 8'h20;
	localparam logic [7:0] OFS_IRQCLR  = 8'h24;
	localparam logic [7:0] OFS_PORT    = 8'h28;

	// Event bit positions in the status, enable and clear registers.
	localparam int unsigned EV_W       = 4;
	localparam int unsigned EV_THR_WR  = 0;
	localparam int unsigned EV_RBR_RD  = 1;
	localparam int unsigned EV_CFG_WR  = 2;
	localparam int unsigned EV_PIN_RST = 3;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       rst_n;
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [2:0] addr;
		logic [7:0] data;
	} mphp_pins_t;

	typedef struct packed {
		logic [7:0] dlm;
		logic [7:0] dll;
		logic [7:0] mcr;
		logic [7:0] lcr;
	} mphp_cfg_t;

	localparam logic [14:0] PINS_IDLE = 15'h7800;
	localparam mphp_cfg_t DEF_CFG = '{dlm: DEF_DLM, dll: DEF_DLL,
		mcr: DEF_MCR, lcr: DEF_LCR};

endpackage : mphp_pkg

/* File: verilog/mphp_ready_timer.sv */
// Readiness timer that holds the port off for a fixed time after reset.
`timescale 1ns/10ps
`default_nettype none
module mphp_ready_timer #(
	parameter int unsigned CYCLES = mphp_pkg::READY_CYCLES
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	output logic      ready_o
);

	localparam logic [mphp_pkg::READY_CNT_W-1:0] LAST =
		(mphp_pkg::READY_CNT_W)'(CYCLES - 1);

	logic [mphp_pkg::READY_CNT_W-1:0] cnt_r;
	logic [mphp_pkg::READY_CNT_W-1:0] cnt_nxt;
	logic                             ready_r;
	logic                             ready_nxt;

	// Count up once and stop when the interval has elapsed.
	always_comb begin
		cnt_nxt   = ready_r ? cnt_r : cnt_r + 1'b1;
		ready_nxt = ready_r | (cnt_r == LAST);
	end

	// Registers restart on every reset.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt_r   <= '0;
			ready_r <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			ready_r <= ready_nxt;
		end
	end

	assign ready_o = ready_r;

endmodule : mphp_ready_timer
`default_nettype wire
